// >>> core/spfwc_pkg.sv
// shared constants and types of the serial page flash write control
package spfwc_pkg;
  // ----------------------------------------------------------------
  // instruction codes (arbitrary values, not tied to any part)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ENABLE_MODIFY = 8'h11;
  localparam logic [7:0] CMD_DISABLE_MODIFY = 8'h12;
  localparam logic [7:0] CMD_READ_STATUS = 8'h13;
  localparam logic [7:0] CMD_PAGE_REWRITE = 8'h21;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h22;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h31;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h32;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'h41;
  localparam logic [7:0] CMD_DEEP_RELEASE = 8'h42;
  // ----------------------------------------------------------------
  // array geometry, protection and status layout
  // ----------------------------------------------------------------
  localparam logic [2:0] TOP_SECTOR = 3'h7;
  localparam logic [7:0] LAST_BYTE = 8'hFF;
  localparam logic [2:0] ADDR_BYTES_DONE = 3'h4;
  localparam logic [2:0] SYNC_RST = 3'h2;
  localparam int STAT_WIP_POS = 0;
  localparam int STAT_WEL_POS = 1;
  localparam int STAT_BP_POS = 2;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MOP_READ, MOP_ERASE_PAGE, MOP_ERASE_SECTOR, MOP_PROGRAM} spfwc_mop_t;
  typedef enum logic [1:0] {K_REWRITE, K_PROGRAM, K_ERASE_PAGE, K_ERASE_SECTOR} spfwc_kind_t;
  typedef enum logic [1:0] {CY_IDLE, CY_FILL, CY_ERASE, CY_PROG} spfwc_cyc_t;
  typedef struct packed {
    spfwc_mop_t op;
    logic [23:0] addr;
    logic [7:0] wdata;
  } spfwc_mreq_t;
endpackage

// >>> core/spfwc_sync.sv
// two-stage synchroniser for pins from outside the system clock domain
module spfwc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else if (en_i)
    begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule

// >>> core/spfwc_write_ctrl.sv
// serial command decode, page buffer and internal write cycle control
// How it works
// R01: freeze pin low holds the block protect size; protected area refuses modify commands.
// R02: older process with top lock pin low makes the top 256 pages read-only.
// R03: top lock pin high adds no protection to the top 256 pages.
// R04: both clock polarities; sample on rising serial clock, drive on falling.
// R05: master parks the serial clock at either idle level; both are handled.
// R06: master selects only one device at a time on a shared bus.
// R07: output is high impedance whenever the device is not selected.
// R08: master sends enable-modify, then opcode, three address bytes and data.
// R09: one sequence loads up to 256 bytes of one page; program only clears bits.
// R10: rewrite is select low, opcode, 24-bit address, data, select high.
// R11: data bytes go to the buffer starting at the low address byte.
// R12: select rise after rewrite merges unloaded bytes, erases, then programs the page.
// R13: page program never erases and never sets bits back to one.
// R14: cycle-in-progress flag is set for the whole internal cycle.
// R15: deselected during a cycle stays active until it ends, then standby.
// R16: deep sleep command enters deep power-down until the release command.
// R17: in deep power-down all commands but release are ignored.
// R18: host holds reset low until supply is good.
// R19: master should send one page's bytes in a single sequence.
// R20: no command accepted after reset until a select falling edge is seen.
// R21: reset low forces the output to high impedance and aborts internal work.
// R22: modify commands execute only when the clock count is a multiple of eight.
// R23: modify latch clears on reset, disable, and completion of each modify command.
// R24: buffer pointer increments per data byte and wraps within the page.
module spfwc_write_ctrl (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic freeze_protect_n_i,
  input wire logic top_sector_lock_n_i,
  input wire logic older_process_i,
  input wire logic [2:0] block_protect_bits_i,
  output logic mem_req_valid_o,
  output spfwc_pkg::spfwc_mreq_t mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  output logic cycle_in_progress_flag_o,
  output logic modify_enable_latch_o,
  output logic active_mode_o,
  output logic deep_sleep_o
);
  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic sclk_s, cs_n_s, mosi_s, frz_n_s, tsl_n_s;
  logic sclk_q_ff, cs_q_ff;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;

  spfwc_sync #(.W(5), .RST_VAL(5'h0A)) u_sync (
    .clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .en_i(ce_i),
    .d_i({spi_clk_i, spi_cs_n_i, spi_mosi_i, freeze_protect_n_i, top_sector_lock_n_i}),
    .q_o({sclk_s, cs_n_s, mosi_s, frz_n_s, tsl_n_s})
  );

  // edges work from either idle level of the serial clock
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sclk_q_ff <= 1'b0;
      cs_q_ff <= 1'b1;
    end
    else if (ce_i)
    begin
      sclk_q_ff <= sclk_s;
      cs_q_ff <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_q_ff & ~cs_n_s; // R04 R05
  assign sclk_fall = ~sclk_s & sclk_q_ff & ~cs_n_s; // R04
  assign cs_fall = ~cs_n_s & cs_q_ff;
  assign cs_rise = cs_n_s & ~cs_q_ff;

  // ----------------------------------------------------------------
  // serial command state
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt_ff, nxt_bit_cnt, byte_cnt_ff, nxt_byte_cnt;
  logic [7:0] shift_ff, nxt_shift, opcode_ff, nxt_opcode, ptr_ff, nxt_ptr, out_ff, nxt_out;
  logic [23:0] addr_ff, nxt_addr;
  logic [255:0] loaded_ff, nxt_loaded;
  logic [2:0] bp_ff, nxt_bp;
  logic miso_ff, nxt_miso, armed_ff, nxt_armed, wel_ff, nxt_wel, deep_ff, nxt_deep, seen_ff, nxt_seen;
  logic [7:0] sh_new, status;
  logic busy, start, cyc_done, load_we, is_load_op, prot, modify_ok;
  spfwc_pkg::spfwc_kind_t start_kind;

  assign busy = cycle_in_progress_flag_o;
  assign sh_new = {shift_ff[6:0], mosi_s};
  assign is_load_op = (opcode_ff == spfwc_pkg::CMD_PAGE_REWRITE) | (opcode_ff == spfwc_pkg::CMD_PAGE_PROGRAM);
  assign status = 8'(({bp_ff} << spfwc_pkg::STAT_BP_POS) | ({wel_ff} << spfwc_pkg::STAT_WEL_POS)
                  | ({busy} << spfwc_pkg::STAT_WIP_POS));

  // protected area from the held block protect bits and the top lock pin
  always_comb
  begin
    case (bp_ff)
      3'h0: prot = 1'b0;
      3'h1: prot = addr_ff[18:16] == spfwc_pkg::TOP_SECTOR;
      3'h2: prot = addr_ff[18:17] == 2'h3;
      3'h3: prot = addr_ff[18];
      default: prot = 1'b1;
    endcase
    if (older_process_i && !tsl_n_s && addr_ff[18:16] == spfwc_pkg::TOP_SECTOR) // R02 R03
      prot = 1'b1;
  end

  // an accepted modify command needs the latch, awake, idle, aligned clocks, open area
  assign modify_ok = armed_ff & wel_ff & ~deep_ff & ~busy & (bit_cnt_ff == 3'h0) // R20 R22 R17
                     & (byte_cnt_ff == spfwc_pkg::ADDR_BYTES_DONE) & ~prot; // R01

  always_comb
  begin
    nxt_bit_cnt = bit_cnt_ff;
    nxt_byte_cnt = byte_cnt_ff;
    nxt_shift = shift_ff;
    nxt_opcode = opcode_ff;
    nxt_ptr = ptr_ff;
    nxt_out = out_ff;
    nxt_addr = addr_ff;
    nxt_loaded = loaded_ff;
    nxt_miso = miso_ff;
    nxt_armed = armed_ff;
    nxt_wel = wel_ff;
    nxt_deep = deep_ff;
    nxt_seen = seen_ff;
    nxt_bp = frz_n_s ? block_protect_bits_i : bp_ff; // R01
    load_we = 1'b0;
    start = 1'b0;
    start_kind = spfwc_pkg::K_REWRITE;
    if (cs_fall)
    begin
      nxt_armed = 1'b1; // R20
      nxt_bit_cnt = 3'h0;
      nxt_byte_cnt = 3'h0;
      nxt_out = 8'h00;
      nxt_seen = 1'b0;
      if (!busy)
        nxt_loaded = '0;
    end
    else if (sclk_rise)
    begin
      nxt_shift = sh_new;
      nxt_bit_cnt = bit_cnt_ff + 3'h1;
      if (bit_cnt_ff == 3'h7)
      begin
        if (byte_cnt_ff != spfwc_pkg::ADDR_BYTES_DONE)
          nxt_byte_cnt = byte_cnt_ff + 3'h1;
        if (byte_cnt_ff == 3'h0)
        begin
          nxt_opcode = sh_new;
          if (sh_new == spfwc_pkg::CMD_READ_STATUS && !deep_ff) // R14 R17
            nxt_out = status;
        end
        else if (byte_cnt_ff != spfwc_pkg::ADDR_BYTES_DONE)
        begin
          if (!busy)
            nxt_addr = {addr_ff[15:0], sh_new}; // R10
          if (byte_cnt_ff == 3'h3)
            nxt_ptr = sh_new; // R11
        end
        else if (is_load_op && !busy && !deep_ff)
        begin
          load_we = 1'b1; // R09 R11
          nxt_loaded[ptr_ff] = 1'b1;
          nxt_ptr = ptr_ff + 8'h01; // R24
          nxt_seen = 1'b1;
        end
      end
    end
    else if (sclk_fall)
    begin
      nxt_miso = out_ff[7]; // R04
      nxt_out = {out_ff[6:0], out_ff[7]};
    end
    if (cs_rise && armed_ff && bit_cnt_ff == 3'h0)
    begin
      case (opcode_ff)
        spfwc_pkg::CMD_ENABLE_MODIFY: nxt_wel = wel_ff | (~deep_ff & ~busy); // R08
        spfwc_pkg::CMD_DISABLE_MODIFY: nxt_wel = wel_ff & deep_ff; // R23
        spfwc_pkg::CMD_DEEP_SLEEP: nxt_deep = deep_ff | ~busy; // R16
        spfwc_pkg::CMD_DEEP_RELEASE: nxt_deep = 1'b0; // R16
        spfwc_pkg::CMD_PAGE_REWRITE:
        begin
          start = modify_ok & seen_ff; // R12
          start_kind = spfwc_pkg::K_REWRITE;
        end
        spfwc_pkg::CMD_PAGE_PROGRAM:
        begin
          start = modify_ok & seen_ff;
          start_kind = spfwc_pkg::K_PROGRAM;
        end
        spfwc_pkg::CMD_PAGE_ERASE:
        begin
          start = modify_ok;
          start_kind = spfwc_pkg::K_ERASE_PAGE;
        end
        spfwc_pkg::CMD_SECTOR_ERASE:
        begin
          start = modify_ok;
          start_kind = spfwc_pkg::K_ERASE_SECTOR;
        end
        default: nxt_wel = wel_ff;
      endcase
    end
    if (cyc_done)
      nxt_wel = 1'b0; // R23
  end

  // reset clears the latch and leaves the device waiting for a select edge
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      opcode_ff <= 8'h00;
      ptr_ff <= 8'h00;
      out_ff <= 8'h00;
      addr_ff <= 24'h000000;
      loaded_ff <= '0;
      miso_ff <= 1'b0;
      armed_ff <= 1'b0;
      wel_ff <= 1'b0; // R23
      deep_ff <= 1'b0;
      seen_ff <= 1'b0;
      bp_ff <= 3'h0;
    end
    else if (ce_i)
    begin
      bit_cnt_ff <= nxt_bit_cnt;
      byte_cnt_ff <= nxt_byte_cnt;
      shift_ff <= nxt_shift;
      opcode_ff <= nxt_opcode;
      ptr_ff <= nxt_ptr;
      out_ff <= nxt_out;
      addr_ff <= nxt_addr;
      loaded_ff <= nxt_loaded;
      miso_ff <= nxt_miso;
      armed_ff <= nxt_armed;
      wel_ff <= nxt_wel;
      deep_ff <= nxt_deep;
      seen_ff <= nxt_seen;
      bp_ff <= nxt_bp;
    end
  end

  // ----------------------------------------------------------------
  // internal cycle: merge, erase, program
  // ----------------------------------------------------------------
  spfwc_pkg::spfwc_cyc_t state_ff, nxt_state;
  spfwc_pkg::spfwc_kind_t kind_ff, nxt_kind;
  logic [7:0] idx_ff, nxt_idx;
  logic [15:0] page_ff, nxt_page;
  logic [7:0] page_buf [256];
  logic fill_we;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_idx = idx_ff;
    nxt_page = page_ff;
    fill_we = 1'b0;
    cyc_done = 1'b0;
    mem_req_valid_o = 1'b0;
    mem_req_o = '{op: spfwc_pkg::MOP_READ, addr: {page_ff, idx_ff}, wdata: page_buf[idx_ff]};
    case (state_ff)
      spfwc_pkg::CY_IDLE:
        if (start)
        begin
          nxt_kind = start_kind;
          nxt_idx = 8'h00;
          nxt_page = addr_ff[23:8];
          nxt_state = (start_kind == spfwc_pkg::K_REWRITE) ? spfwc_pkg::CY_FILL
                    : (start_kind == spfwc_pkg::K_PROGRAM) ? spfwc_pkg::CY_PROG : spfwc_pkg::CY_ERASE;
        end
      spfwc_pkg::CY_FILL:
      begin
        // unloaded bytes come from the page itself
        mem_req_valid_o = ~loaded_ff[idx_ff]; // R12
        fill_we = mem_req_valid_o & mem_ack_i;
        if (loaded_ff[idx_ff] || mem_ack_i)
        begin
          nxt_idx = idx_ff + 8'h01;
          if (idx_ff == spfwc_pkg::LAST_BYTE)
            nxt_state = spfwc_pkg::CY_ERASE;
        end
      end
      spfwc_pkg::CY_ERASE:
      begin
        mem_req_valid_o = 1'b1;
        mem_req_o.op = (kind_ff == spfwc_pkg::K_ERASE_SECTOR) ? spfwc_pkg::MOP_ERASE_SECTOR
                     : spfwc_pkg::MOP_ERASE_PAGE;
        if (mem_ack_i)
        begin
          nxt_idx = 8'h00;
          cyc_done = kind_ff != spfwc_pkg::K_REWRITE;
          nxt_state = cyc_done ? spfwc_pkg::CY_IDLE : spfwc_pkg::CY_PROG;
        end
      end
      spfwc_pkg::CY_PROG:
      begin
        // plain program skips unloaded bytes, so no bit is ever raised
        mem_req_valid_o = loaded_ff[idx_ff] | (kind_ff == spfwc_pkg::K_REWRITE); // R13
        mem_req_o.op = spfwc_pkg::MOP_PROGRAM;
        if (!mem_req_valid_o || mem_ack_i)
        begin
          nxt_idx = idx_ff + 8'h01;
          if (idx_ff == spfwc_pkg::LAST_BYTE)
          begin
            cyc_done = 1'b1;
            nxt_state = spfwc_pkg::CY_IDLE;
          end
        end
      end
      default: nxt_state = spfwc_pkg::CY_IDLE;
    endcase
  end

  // reset drops any cycle in progress; the array may be left corrupted
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= spfwc_pkg::CY_IDLE; // R21
      kind_ff <= spfwc_pkg::K_REWRITE;
      idx_ff <= 8'h00;
      page_ff <= 16'h0000;
    end
    else if (ce_i)
    begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      idx_ff <= nxt_idx;
      page_ff <= nxt_page;
    end
  end

  // page buffer: serial load and merge fill never overlap
  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i && fill_we)
      page_buf[idx_ff] <= mem_rdata_i; // R12
    else if (ce_i && load_we)
      page_buf[ptr_ff] <= sh_new; // R11
  end

  assign cycle_in_progress_flag_o = state_ff != spfwc_pkg::CY_IDLE; // R14
  assign modify_enable_latch_o = wel_ff;
  assign active_mode_o = ~cs_n_s | busy; // R15
  assign deep_sleep_o = deep_ff;
  assign spi_miso_o = miso_ff;
  assign spi_miso_oe_o = ~cs_n_s; // R07 R21

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_OE_OFF: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) cs_n_s |-> !spi_miso_oe_o) // R07
    else $error("output driven while deselected");
  AST_WIP_SET: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (ce_i && start) |=> cycle_in_progress_flag_o) // R14
    else $error("busy flag not set after start");
  AST_ALIGN: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) start |-> bit_cnt_ff == 3'h0) // R22
    else $error("cycle started on misaligned clock count");
  AST_NO_PROT: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) start |-> !prot) // R01
    else $error("cycle started in protected area");
  AST_TOP_LOCK: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (older_process_i && !tsl_n_s && addr_ff[18:16] == spfwc_pkg::TOP_SECTOR) |-> !start) // R02
    else $error("top pages modified while locked");
  AST_DEEP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (ce_i && deep_ff && opcode_ff != spfwc_pkg::CMD_DEEP_RELEASE) |=> deep_ff && !cycle_in_progress_flag_o) // R17
    else $error("command acted in deep power-down");
  AST_WEL_CLR: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (ce_i && cyc_done) |=> !modify_enable_latch_o && !cycle_in_progress_flag_o) // R23
    else $error("modify latch not cleared at completion");
  AST_PTR_WRAP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (ce_i && load_we && ptr_ff == spfwc_pkg::LAST_BYTE) |=> ptr_ff == 8'h00) // R24
    else $error("buffer pointer failed to wrap");
  AST_ARMED: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) !armed_ff |-> !start) // R20
    else $error("command accepted before select edge");
  AST_ACTIVE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cycle_in_progress_flag_o |-> active_mode_o) // R15
    else $error("standby during internal cycle");
endmodule

// >>> sim/spfwc_array_model.sv
// behavioural flash array that answers the write control's array requests
module spfwc_array_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic req_valid_i,
  input wire spfwc_pkg::spfwc_mreq_t req_i,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  int dly;
  int base;
  // erased cells read as all ones
  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // ----------------------------------------------------------------
  // request handling
  // ----------------------------------------------------------------
  // random wait of 0..3 cycles so prompt and slow answers both occur
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack_o <= 1'b0;
      rdata_o <= 8'h00;
      dly = 0;
    end
    else if (ack_o || !req_valid_i)
    begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;  // read data is not held past the answer
      dly = $urandom_range(3, 0);
    end
    else if (dly > 0)
      dly--;
    else
    begin
      ack_o <= 1'b1;
      base = int'(req_i.addr);
      case (req_i.op)
        spfwc_pkg::MOP_READ: rdata_o <= rd(base);
        spfwc_pkg::MOP_PROGRAM: mem[base] = rd(base) & req_i.wdata;  // cells only fall to zero
        spfwc_pkg::MOP_ERASE_PAGE:
          for (int i = 0; i < 256; i++)
            mem.delete((base & 32'hFFFF00) + i);
        default:
          for (int i = 0; i < 65536; i++)
            mem.delete((base & 32'hFF0000) + i);
      endcase
    end
  end
endmodule

// >>> sim/spfwc_write_ctrl_tb.sv
// self-checking bench of the serial page flash write control
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module spfwc_write_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, rstn_i = 1'b1, ce_i = 1'b1, spi_clk_i = 1'b0, spi_cs_n_i = 1'b1, spi_mosi_i = 1'b0;
  logic freeze_protect_n_i = 1'b1, top_sector_lock_n_i = 1'b1, older_process_i = 1'b0, mode3 = 1'b0;
  logic [2:0] block_protect_bits_i = 3'h0, held = 3'h0;
  logic spi_miso_o, spi_miso_oe_o, mem_req_valid_o, mem_ack_i, cycle_in_progress_flag_o;
  logic modify_enable_latch_o, active_mode_o, deep_sleep_o;
  logic [7:0] mem_rdata_i, rx;
  spfwc_pkg::spfwc_mreq_t mem_req_o;
  logic [7:0] wq[$], sent[$], exp_mem[int];
  int miscompares = 0, tests_run = 0, cycles = 0, a;
  logic [7:0] ops [6] = '{spfwc_pkg::CMD_PAGE_PROGRAM, spfwc_pkg::CMD_PAGE_REWRITE, spfwc_pkg::CMD_PAGE_PROGRAM,
    spfwc_pkg::CMD_PAGE_REWRITE, spfwc_pkg::CMD_PAGE_ERASE, spfwc_pkg::CMD_SECTOR_ERASE};
  // bp, freeze_n, top_lock_n, older, stray bits, disable instead of enable, accepted
  int cases [8][7] = '{'{1, 1, 1, 0, 0, 0, 0}, '{0, 0, 1, 0, 0, 0, 0}, '{0, 1, 0, 1, 0, 0, 0},
    '{0, 1, 0, 0, 0, 0, 1}, '{0, 1, 1, 1, 0, 0, 1}, '{0, 1, 1, 0, 3, 0, 0}, '{0, 1, 1, 0, 0, 1, 0},
    '{0, 1, 1, 0, 0, 0, 1}};
  spfwc_write_ctrl DUT (.sys_clk_i, .rstn_i, .ce_i, .spi_clk_i, .spi_cs_n_i, .spi_mosi_i, .spi_miso_o,
    .spi_miso_oe_o, .freeze_protect_n_i, .top_sector_lock_n_i, .older_process_i, .block_protect_bits_i,
    .mem_req_valid_o, .mem_req_o, .mem_ack_i, .mem_rdata_i, .cycle_in_progress_flag_o, .modify_enable_latch_o,
    .active_mode_o, .deep_sleep_o);
  spfwc_array_model ARR (.clk_i(sys_clk_i), .rstn_i(rstn_i), .req_valid_i(mem_req_valid_o), .req_i(mem_req_o),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  // 50 MHz system clock
  initial
  begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // ----------------------------------------------------------------
  // serial master tasks
  // ----------------------------------------------------------------
  // 160 ns serial period; miso sampled just before each rise
  task automatic spi_bits(logic [7:0] b, int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      @(negedge sys_clk_i);
      spi_clk_i = 1'b0;
      spi_mosi_i = b[i];
      repeat (4) @(negedge sys_clk_i);
      rx = {rx[6:0], spi_miso_o};
      spi_clk_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
    end
  endtask
  // one select frame: opcode, optional address, queued data, stray bits
  task automatic frame(logic [7:0] op, int ad, int xb);
    @(negedge sys_clk_i);
    spi_clk_i = mode3;  // clock parked at the mode's idle level
    repeat (4) @(negedge sys_clk_i);
    spi_cs_n_i = 1'b0;  // only device on this bus; fall arms it
    repeat (6) @(negedge sys_clk_i);
    `CHK("oe selected", 1'b1, spi_miso_oe_o)
    spi_bits(op, 8);
    if (ad >= 0)
      for (int i = 16; i >= 0; i -= 8)
        spi_bits(8'(ad >> i), 8);  // A23 first
    foreach (wq[i])
      spi_bits(wq[i], 8);
    spi_bits(8'($urandom), xb);
    @(negedge sys_clk_i);
    spi_clk_i = mode3;
    repeat (4) @(negedge sys_clk_i);
    spi_cs_n_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    `CHK("oe deselected", 1'b0, spi_miso_oe_o)
    wq = {};
  endtask
  // latch command first, then the modify frame with random data
  task automatic write_op(logic [7:0] op, int ad, int n, int xb, logic [7:0] pre);
    frame(pre, -1, 0);
    sent = {};
    repeat (n) sent.push_back(8'($urandom));
    wq = sent;
    frame(op, ad, xb);
  endtask
  task automatic st_read();
    wq = {8'h00};
    frame(spfwc_pkg::CMD_READ_STATUS, -1, 0);
  endtask
  // bounded wait for the internal cycle to end
  task automatic wait_idle();
    for (int k = 0; k < 20000 && cycle_in_progress_flag_o !== 1'b0; k++)
      @(negedge sys_clk_i);
    `CHK("cycle done", 1'b0, cycle_in_progress_flag_o)
  endtask
  // ----------------------------------------------------------------
  // reference array
  // ----------------------------------------------------------------
  function automatic logic [7:0] ev(int x);
    return exp_mem.exists(x) ? exp_mem[x] : 8'hFF;
  endfunction
  // data lands from the low address byte on, wrapping in the page
  task automatic ref_apply(logic [7:0] op, int ad);
    int pg;
    int sp;
    pg = ad & 32'hFFFF00;
    sp = (op == spfwc_pkg::CMD_SECTOR_ERASE) ? 65536 : 256;
    if (op == spfwc_pkg::CMD_PAGE_ERASE || op == spfwc_pkg::CMD_SECTOR_ERASE)
      for (int i = 0; i < sp; i++)
        exp_mem.delete((ad & ~(sp - 1)) + i);
    foreach (sent[i])
      exp_mem[pg + ((ad + i) & 255)] = (op == spfwc_pkg::CMD_PAGE_PROGRAM) ? ev(pg + ((ad + i) & 255)) & sent[i]
        : sent[i];
  endtask
  task automatic check_page(int ad);
    for (int i = 0; i < 256; i++)
      `CHK("array byte", ev((ad & 32'hFFFF00) + i), ARR.rd((ad & 32'hFFFF00) + i))
  endtask
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard well above the expected run length
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      miscompares++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(54220));
    // a real falling edge, so every asynchronous reset branch is taken
    @(negedge sys_clk_i);
    rstn_i = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    `CHK("oe in reset", 1'b0, spi_miso_oe_o)
    `CHK("latch in reset", 1'b0, modify_enable_latch_o)
    rstn_i = 1'b1;  // released with supply settled
    repeat (5) @(negedge sys_clk_i);
    a = int'({5'h00, 3'($urandom_range(6, 0)), 16'($urandom)});
    foreach (ops[t])
    begin
      mode3 = 1'(t);  // both clock idle levels are met by the modify commands
      a = (a & 32'hFFFF00) | ((t == 1) ? 32'hFC : 32'($urandom_range(255, 0)));
      write_op(ops[t], a, (t > 3) ? 0 : ((t == 1) ? 8 : $urandom_range(6, 1)), 0, spfwc_pkg::CMD_ENABLE_MODIFY);
      if (ops[t] == spfwc_pkg::CMD_PAGE_REWRITE)
      begin
        `CHK("busy after rise", 1'b1, cycle_in_progress_flag_o)
        `CHK("active while busy", 1'b1, active_mode_o)
        st_read();
        `CHK("status polled", 8'h03, rx)
      end
      wait_idle();
      `CHK("standby after cycle", 1'b0, active_mode_o)
      `CHK("latch after cycle", 1'b0, modify_enable_latch_o)
      ref_apply(ops[t], a);
      check_page(a);
    end
    for (int c = 0; c < 8; c++)
    begin
      mode3 = 1'($urandom);
      freeze_protect_n_i = cases[c][1];
      repeat (4) @(negedge sys_clk_i);
      block_protect_bits_i = 3'(cases[c][0]);
      top_sector_lock_n_i = cases[c][2];
      older_process_i = cases[c][3];
      held = freeze_protect_n_i ? block_protect_bits_i : held;
      a = int'({5'h00, 3'h7, 16'($urandom)});
      write_op(spfwc_pkg::CMD_PAGE_PROGRAM, a, 2, cases[c][4],
        cases[c][5] ? spfwc_pkg::CMD_DISABLE_MODIFY : spfwc_pkg::CMD_ENABLE_MODIFY);
      wait_idle();
      if (cases[c][6])
        ref_apply(spfwc_pkg::CMD_PAGE_PROGRAM, a);
      check_page(a);
      st_read();
      // refusal after enable-modify leaves the latch set; the cycle is over, so busy reads zero
      `CHK("status", {3'h0, held, 1'(!cases[c][6] && !cases[c][5]), 1'b0}, rx)
    end
    frame(spfwc_pkg::CMD_DEEP_SLEEP, -1, 0);
    `CHK("deep sleep", 1'b1, deep_sleep_o)
    a = int'({5'h00, 3'h2, 16'($urandom)});
    write_op(spfwc_pkg::CMD_PAGE_REWRITE, a, 3, 0, spfwc_pkg::CMD_ENABLE_MODIFY);
    `CHK("asleep busy", 1'b0, cycle_in_progress_flag_o)
    `CHK("asleep latch", 1'b0, modify_enable_latch_o)
    frame(spfwc_pkg::CMD_DEEP_RELEASE, -1, 0);
    `CHK("deep released", 1'b0, deep_sleep_o)
    check_page(a);
    write_op(spfwc_pkg::CMD_PAGE_REWRITE, a, 4, 0, spfwc_pkg::CMD_ENABLE_MODIFY);
    repeat (30) @(negedge sys_clk_i);
    `CHK("busy before reset", 1'b1, cycle_in_progress_flag_o)
    rstn_i = 1'b0;
    @(negedge sys_clk_i);
    `CHK("busy in reset", 1'b0, cycle_in_progress_flag_o)
    `CHK("request in reset", 1'b0, mem_req_valid_o)
    `CHK("latch cleared", 1'b0, modify_enable_latch_o)
    rstn_i = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    a = int'({5'h00, 3'h1, 16'($urandom)});
    write_op(spfwc_pkg::CMD_PAGE_PROGRAM, a, 5, 0, spfwc_pkg::CMD_ENABLE_MODIFY);
    wait_idle();
    ref_apply(spfwc_pkg::CMD_PAGE_PROGRAM, a);
    check_page(a);
    final_report();
  end
endmodule
